// >>> core/masked_req_reg.sv
// One sixteen bit request register with masked writes
`timescale 1ns/1ps
`default_nettype none
`include "rst_bank_map.svh"
module masked_req_reg #(
  parameter int unsigned IDX = 0,
  parameter logic [15:0] RW_MASK = `USB_RW_MASK
) (
  input wire logic pclk,
  input wire logic presetn,
  req_write_if.sink wr,
  output logic [15:0] req_q
);
  logic [15:0] req_d;
  logic [15:0] upd;

  always_comb begin
    upd = wr.wr_en[IDX] ? (wr.wr_mask & RW_MASK) : '0;
    req_d = (req_q & ~upd) | (wr.wr_val & upd);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q <= `REQ_RESET;
    end else begin
      req_q <= req_d;
    end
  end
endmodule
`default_nettype wire

// >>> core/req_write_if.sv
// Write strobe and data carried from the bus slave to each request register
`timescale 1ns/1ps
`default_nettype none
interface req_write_if;
  logic [3:0] wr_en;
  logic [15:0] wr_mask;
  logic [15:0] wr_val;
  modport source (output wr_en, output wr_mask, output wr_val);
  modport sink (input wr_en, input wr_mask, input wr_val);
endinterface
`default_nettype wire

// >>> core/rst_bank_map.svh
// Register offsets, field layouts and reset values of the soft reset request bank
`ifndef RST_BANK_MAP_SVH
`define RST_BANK_MAP_SVH
`define DISP_OFFSET 12'h30C
`define USB_OFFSET 12'h310
`define STOR_OFFSET 12'h314
`define NEXT_OFFSET 12'h318
`define REQ_RESET 16'h0000
`define DISP_RW_MASK 16'h07FF
`define USB_RW_MASK 16'hFFFF
`define STOR_RW_MASK 16'h767F
`define NEXT_RW_MASK 16'hFFFF
`define MASK_MSB 31
`define MASK_LSB 16
`define REQ_MSB 15
`define ADDR_MSB 11
`define REG_COUNT 4
`define FULL_STRB 4'hF
`define DISP_REQ_MSB 10
`define VFA_BIT 0
`define DUAL_BIT 3
`endif

// >>> core/rst_bank_pkg.sv
// Types shared by the soft reset request bank
package rst_bank_pkg;
  typedef logic [15:0] req_word_t;
  typedef enum logic [1:0] {
    sel_disp,
    sel_usb,
    sel_stor,
    sel_next
  } reg_sel_t;
endpackage

// >>> core/soft_reset_request_bank.sv
// APB bank of masked soft reset request registers
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "rst_bank_map.svh"
module soft_reset_request_bank (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [10:0] disp_reset_req,
  output logic [15:0] usb_reset_req,
  output logic [15:0] stor_reset_req,
  output logic [15:0] next_reset_req,
  output logic video_fabric_axi_reset_request,
  output logic dual_role_usb_reset_request
);
  // ****************************************************
  // Address decode
  // ****************************************************
  req_write_if wr ();
  logic hit;
  rst_bank_pkg::reg_sel_t sel;
  logic [15:0] req_q [`REG_COUNT];
  logic [15:0] rd_word;
  logic [31:0] prdata_d;
  logic [31:0] prdata_q;
  logic access;

  assign access = psel & penable;

  always_comb begin
    hit = 1'b1;
    sel = rst_bank_pkg::sel_disp;
    case (paddr)
      `DISP_OFFSET: sel = rst_bank_pkg::sel_disp;
      `USB_OFFSET: sel = rst_bank_pkg::sel_usb;
      `STOR_OFFSET: sel = rst_bank_pkg::sel_stor;
      `NEXT_OFFSET: sel = rst_bank_pkg::sel_next;
      default: hit = 1'b0;
    endcase
  end

  // ****************************************************
  // Write path
  // ****************************************************
  always_comb begin
    wr.wr_en = 4'h0;
    if (access && pwrite && hit && (pstrb == `FULL_STRB)) begin
      wr.wr_en[sel] = 1'b1;
    end
    wr.wr_mask = pwdata[`MASK_MSB:`MASK_LSB];
    wr.wr_val = pwdata[`REQ_MSB:0];
  end

  localparam logic [15:0] RW_MASKS [`REG_COUNT] = '{
    `DISP_RW_MASK, `USB_RW_MASK, `STOR_RW_MASK, `NEXT_RW_MASK
  };

  genvar g;
  generate
    for (g = 0; g < `REG_COUNT; g++) begin : g_reg
      masked_req_reg #(
        .IDX(g),
        .RW_MASK(RW_MASKS[g])
      ) u_reg (
        .pclk(pclk),
        .presetn(presetn),
        .wr(wr),
        .req_q(req_q[g])
      );
    end
  endgenerate

  // ****************************************************
  // Read path
  // ****************************************************
  always_comb begin
    rd_word = hit ? req_q[sel] : 16'h0000;
    prdata_d = prdata_q;
    if (psel && !penable && !pwrite) begin
      prdata_d = {16'h0000, rd_word};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = access & ~hit;

  // ****************************************************
  // Reset outputs
  // ****************************************************
  assign disp_reset_req = req_q[0][`DISP_REQ_MSB:0];
  assign usb_reset_req = req_q[1];
  assign stor_reset_req = req_q[2];
  assign next_reset_req = req_q[3];
  assign video_fabric_axi_reset_request = req_q[0][`VFA_BIT];
  assign dual_role_usb_reset_request = req_q[1][`DUAL_BIT];
endmodule
`default_nettype wire

// >>> dv/rst_targets.sv
// Reset inputs of the blocks behind the bank
`timescale 1ns/1ps
`default_nettype none
module rst_targets (
  input wire logic [15:0] req,
  output logic [15:0] held
);
  assign held = req;
endmodule
`default_nettype wire

// >>> dv/soft_reset_request_bank_tb_top.sv
// Bench of the soft reset request bank
`timescale 1ns/1ps
`default_nettype none
module soft_reset_request_bank_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, dual;
  logic pslverr, vfa, err;
  logic [3:0] pstrb = 4'hF;
  logic [10:0] disp;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] usb, held, stor, nxt;
  int num_errors = 0, checked = 0;
  always #2.5 pclk = ~pclk;
  soft_reset_request_bank i_soft_reset_request_bank (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .disp_reset_req(disp),
    .usb_reset_req(usb), .stor_reset_req(stor), .next_reset_req(nxt),
    .video_fabric_axi_reset_request(vfa), .dual_role_usb_reset_request(dual));
  rst_targets i_rst_targets (.req(usb), .held);
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s = 4'hF);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'h1, w, a, d, s};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic chk(logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t %h %h", $time, g, e);
    end
  endtask
  task automatic t_regs;
    for (int i = 0; i < 5; i++) begin
      apb(1'h1, 12'h30C + 12'(4 * i), 32'hFFFFFFFF);
      chk({31'h0, err}, {31'h0, i == 4});
      apb(1'h0, 12'h30C + 12'(4 * i), 32'h0);
      chk(rd, 32'(16'(80'h0000FFFF767FFFFF07FF >> 16 * i)));
      chk({31'h0, err}, {31'h0, i == 4});
    end
    chk({21'h0, disp}, 32'h000007FF);
    chk({stor, nxt}, 32'h767FFFFF);
    chk({usb, 14'h0, dual, vfa}, 32'hFFFF0003);
  endtask
  task automatic t_reset;
    @(posedge pclk);
    presetn <= 1'h0;
    @(posedge pclk);
    chk({usb, 14'h0, dual, vfa}, 32'h0);
    chk({stor, nxt}, 32'h0);
    chk({21'h0, disp}, 32'h0);
    presetn <= 1'h1;
    apb(1'h0, 12'h310, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_mask;
    apb(1'h1, 12'h310, 32'h0F0F0505);
    apb(1'h0, 12'h310, 32'h0);
    chk(rd, 32'h0000F5F5);
    chk({held, 15'h0, dual}, 32'hF5F50000);
    apb(1'h1, 12'h310, 32'hFFFF0000, 4'h7);
    apb(1'h0, 12'h310, 32'h0);
    chk(rd, 32'h0000F5F5);
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #20000 num_errors++;
    complete_run;
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    t_mask;
    t_reset;
    complete_run;
  end
endmodule
`default_nettype wire

// >>> dv/srb_props.sv
// Port assertions of the soft reset request bank
`timescale 1ns/1ps
`default_nettype none
module srb_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic dual_role_usb_reset_request,
  input wire logic [11:0] paddr,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [15:0] usb_reset_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] u, m_q, v_q;
  logic r, w;
  assign u = usb_reset_req;
  assign r = psel && penable && !pwrite;
  assign w = psel && penable && pwrite && paddr == 12'h310 && pstrb == 4'hF;
  always_ff @(posedge pclk) {m_q, v_q} <= pwdata;
  AST_SET: assert property (w |=> (u & m_q) == (v_q & m_q)) else $error("set");
  AST_KEEP: assert property (w |=> (u & ~m_q) == ($past(u) & ~m_q)) else $error("kept");
  AST_IDLE: assert property (!w |=> $stable(u)) else $error("idle");
  AST_ALL: assert property (w && pwdata == 32'hFFFFFFFF |=> &u) else $error("all");
  AST_HI: assert property (r |-> !prdata[31:16]) else $error("mask");
  AST_RD: assert property (r && paddr == 12'h310 |-> prdata[15:0] == u) else $error("rd");
  AST_BIT: assert property (dual_role_usb_reset_request == u[3]) else $error("bit");
  AST_INIT: assert property ($rose(presetn) |-> !u) else $error("init");
endmodule
bind soft_reset_request_bank srb_props i_srb_props (.*);
`default_nettype wire
